// *** common/cps_pkg.sv ***
/*
  constants for the conversion format and status block: register offsets,
  field positions, reset values and the operation list.
  assumes an apb slave port with 32-bit data on pclk.
*/
// Operation
// - attenuate linear pcm by shift 0..3
// - expanded log pcm shifted the same way
// - attenuation field resets to zero
// - law select: 0 u-law, 1 a-law
// - status is 16-bit read-only
// - status zero at reset and when disabled
// - nearly-empty set at three words left
// - nearly-empty raises irq when enabled
// - nearly-empty raises input dma request
// - status read clears nearly-empty flag
// - nearly-full raises irq and output dma
// - pcm service flag set on pcm need
// - status bit layout fixed
// - underrun flag, error irq, read clear
// - overrun flag, error irq, read clear
`default_nettype none
package cps_pkg;
  // register byte offsets
  localparam logic [11:0] CPS_OFS_CTRL = 12'h000;
  localparam logic [11:0] CPS_OFS_STATUS = 12'h004;
  localparam logic [11:0] CPS_OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] CPS_OFS_IRQ_MASK = 12'h00C;
  // control fields
  localparam int CPS_CTL_EN = 0;
  localparam int CPS_CTL_LAW = 1;
  localparam int CPS_CTL_ATT_LO = 2;
  localparam int CPS_CTL_LVL_IRQ = 4;
  localparam int CPS_CTL_ERR_IRQ = 5;
  localparam int CPS_CTL_IN_DMA = 6;
  localparam int CPS_CTL_OUT_DMA = 7;
  localparam int CPS_CTL_FREEZE = 8;
  localparam logic [8:0] CPS_CTL_RESET = 9'h000;
  // status fields
  localparam int CPS_ST_NE = 0;
  localparam int CPS_ST_NF = 1;
  localparam int CPS_ST_PCM = 2;
  localparam int CPS_ST_UND = 3;
  localparam int CPS_ST_OVR = 4;
  localparam int CPS_ST_IN_LO = 5;
  localparam int CPS_ST_OUT_LO = 8;
  localparam logic [15:0] CPS_ST_RESET = 16'h0000;
  // fifo level that counts as nearly empty
  localparam logic [2:0] CPS_NEAR_EMPTY = 3'h3;
  // irq event bits: 0 level, 1 error, 2 pcm
  localparam logic [2:0] CPS_IRQ_RESET = 3'h0;
endpackage
`default_nettype wire

// *** logic/cps_shift.sv ***
/*
  pcm attenuator: law-dependent expansion alignment then arithmetic right shift.
  assumes registered inputs on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module cps_shift
  import cps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] pcm_in,
  input wire logic pcm_is_log,
  input wire logic law_alaw,
  input wire logic [1:0] att,
  output logic [15:0] pcm_out
);
  logic [15:0] aligned;
  // ==========================================
  // alignment
  // log left justify
  always_comb
  begin
    if (!pcm_is_log)
      aligned = pcm_in;
    else if (law_alaw)
      aligned = {pcm_in[12:0], 3'h0};
    else
      aligned = {pcm_in[13:0], 2'h0};
  end
  // ==========================================
  // shift
  // arithmetic right shift
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pcm_out <= 16'h0000;
    else
      pcm_out <= $signed(aligned) >>> att;
  end
endmodule
`default_nettype wire

// *** logic/cps_top.sv ***
/*
  format controls and read-clear status word of the cvsd/pcm unit, apb slave.
  assumes the conversion engine and fifos drive the event and level inputs on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module cps_top
  import cps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] input_fill_level,
  input wire logic [2:0] output_fill_level,
  input wire logic output_nearly_full,
  input wire logic pcm_need,
  input wire logic underrun_event,
  input wire logic overrun_event,
  input wire logic [15:0] pcm_in,
  input wire logic pcm_is_log,
  output logic [15:0] pcm_att,
  output logic companding_law_select,
  output logic module_enable_bit,
  output logic in_dma_req,
  output logic out_dma_req,
  output logic irq
);
  logic [8:0] ctrl;
  logic [15:0] status;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] prev_in_fill;
  logic wr, rd, rd_status;
  logic [15:0] rd_clear;
  logic ne_evt;
  logic [2:0] irq_evt;
  logic st_ne, st_nf, st_pcm, st_und, st_ovr;
  logic [2:0] st_in_fill, st_out_fill;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign rd_status = rd && (paddr == CPS_OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign module_enable_bit = ctrl[CPS_CTL_EN];
  assign companding_law_select = ctrl[CPS_CTL_LAW];

  // ==========================================
  // control register
  // reset to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= CPS_CTL_RESET;
    else if (wr && paddr == CPS_OFS_CTRL)
      ctrl <= pwdata[8:0];
  end

  cps_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .pcm_in(pcm_in),
    .pcm_is_log(pcm_is_log),
    .law_alaw(ctrl[CPS_CTL_LAW]),
    .att(ctrl[CPS_CTL_ATT_LO +: 2]),
    .pcm_out(pcm_att)
  );

  // ==========================================
  // status word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_in_fill <= 3'h0;
    else
      prev_in_fill <= input_fill_level;
  end
  assign ne_evt = (input_fill_level == CPS_NEAR_EMPTY) && (prev_in_fill != CPS_NEAR_EMPTY);

  always_comb
  begin
    rd_clear = 16'h0000;
    if (rd_status)
    begin
      rd_clear[CPS_ST_NE] = prdata[CPS_ST_NE];
      if (!ctrl[CPS_CTL_FREEZE])
      begin
        rd_clear[CPS_ST_PCM] = prdata[CPS_ST_PCM];
        rd_clear[CPS_ST_UND] = prdata[CPS_ST_UND];
        rd_clear[CPS_ST_OVR] = prdata[CPS_ST_OVR];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ne <= CPS_ST_RESET[CPS_ST_NE];
    else if (!ctrl[CPS_CTL_EN])
      st_ne <= CPS_ST_RESET[CPS_ST_NE];
    else
      st_ne <= ne_evt | (st_ne & ~rd_clear[CPS_ST_NE]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_nf <= CPS_ST_RESET[CPS_ST_NF];
    else if (!ctrl[CPS_CTL_EN])
      st_nf <= CPS_ST_RESET[CPS_ST_NF];
    else
      st_nf <= output_nearly_full;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_pcm <= CPS_ST_RESET[CPS_ST_PCM];
    else if (!ctrl[CPS_CTL_EN])
      st_pcm <= CPS_ST_RESET[CPS_ST_PCM];
    else
      st_pcm <= pcm_need | (st_pcm & ~rd_clear[CPS_ST_PCM]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_und <= CPS_ST_RESET[CPS_ST_UND];
    else if (!ctrl[CPS_CTL_EN])
      st_und <= CPS_ST_RESET[CPS_ST_UND];
    else
      st_und <= underrun_event | (st_und & ~rd_clear[CPS_ST_UND]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ovr <= CPS_ST_RESET[CPS_ST_OVR];
    else if (!ctrl[CPS_CTL_EN])
      st_ovr <= CPS_ST_RESET[CPS_ST_OVR];
    else
      st_ovr <= overrun_event | (st_ovr & ~rd_clear[CPS_ST_OVR]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_in_fill <= CPS_ST_RESET[CPS_ST_IN_LO +: 3];
    else if (!ctrl[CPS_CTL_EN])
      st_in_fill <= CPS_ST_RESET[CPS_ST_IN_LO +: 3];
    else
      st_in_fill <= input_fill_level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_out_fill <= CPS_ST_RESET[CPS_ST_OUT_LO +: 3];
    else if (!ctrl[CPS_CTL_EN])
      st_out_fill <= CPS_ST_RESET[CPS_ST_OUT_LO +: 3];
    else
      st_out_fill <= output_fill_level;
  end

  assign status = {5'h00, st_out_fill, st_in_fill, st_ovr, st_und, st_pcm, st_nf, st_ne};

  // ==========================================
  // dma requests
  // input dma on nearly empty
  assign in_dma_req = ctrl[CPS_CTL_IN_DMA] && status[CPS_ST_NE];
  assign out_dma_req = ctrl[CPS_CTL_OUT_DMA] && status[CPS_ST_NF];

  // ==========================================
  // interrupts
  // level, error and pcm irq sources
  always_comb
  begin
    irq_evt = 3'h0;
    irq_evt[0] = ctrl[CPS_CTL_LVL_IRQ] && (status[CPS_ST_NE] || status[CPS_ST_NF]);
    irq_evt[1] = ctrl[CPS_CTL_ERR_IRQ] && (status[CPS_ST_UND] || status[CPS_ST_OVR]);
    irq_evt[2] = status[CPS_ST_PCM];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= CPS_IRQ_RESET;
    else if (wr && paddr == CPS_OFS_IRQ_STAT)
      irq_stat <= irq_evt | (irq_stat & ~pwdata[2:0]);
    else
      irq_stat <= irq_evt | irq_stat;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= CPS_IRQ_RESET;
    else if (wr && paddr == CPS_OFS_IRQ_MASK)
      irq_mask <= pwdata[2:0];
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================
  // read mux
  // read only status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        CPS_OFS_CTRL: prdata <= {23'h000000, ctrl};
        CPS_OFS_STATUS: prdata <= {16'h0000, status};
        CPS_OFS_IRQ_STAT: prdata <= {29'h00000000, irq_stat};
        CPS_OFS_IRQ_MASK: prdata <= {29'h00000000, irq_mask};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // checks
  sequence s_status_read;
    rd_status && ctrl[CPS_CTL_EN];
  endsequence

  sequence s_mask_kept;
    !(wr && paddr == CPS_OFS_IRQ_MASK);
  endsequence

  a_ne_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_status && prdata[CPS_ST_NE] && !ne_evt && ctrl[CPS_CTL_EN] |=> !status[CPS_ST_NE])
    else $error("nearly empty not cleared by read");
  a_dis_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[CPS_CTL_EN] |=> status == 16'h0000)
    else $error("status not zero while disabled");
  a_ne_set: assert property (@(posedge pclk) disable iff (!presetn)
    ne_evt && ctrl[CPS_CTL_EN] |=> status[CPS_ST_NE])
    else $error("nearly empty not set");
  a_in_dma: assert property (@(posedge pclk) disable iff (!presetn)
    in_dma_req == (ctrl[CPS_CTL_IN_DMA] && status[CPS_ST_NE]))
    else $error("input dma mismatch");
  a_und_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    status[CPS_ST_UND] && ctrl[CPS_CTL_FREEZE] && ctrl[CPS_CTL_EN] && $stable(ctrl)
    |=> status[CPS_ST_UND])
    else $error("underrun lost in freeze");
  a_ovr_set: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_event && ctrl[CPS_CTL_EN] |=> status[CPS_ST_OVR])
    else $error("overrun not set");
  a_fill_track: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CPS_CTL_EN] |=> status[10:5] == {$past(output_fill_level), $past(input_fill_level)})
    else $error("fill field mismatch");
  a_resv_zero: assert property (@(posedge pclk) disable iff (!presetn)
    status[15:11] == 5'h00)
    else $error("reserved bits set");
  a_lvl_irq: assert property (@(posedge pclk) disable iff (!presetn)
    irq_evt[0] && irq_mask[0] |=> irq)
    else $error("level irq missing");
  a_nf_copy: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CPS_CTL_EN] |=> status[CPS_ST_NF] == $past(output_nearly_full))
    else $error("nearly full not copied");
  a_out_dma: assert property (@(posedge pclk) disable iff (!presetn)
    out_dma_req == (ctrl[CPS_CTL_OUT_DMA] && status[CPS_ST_NF]))
    else $error("output dma mismatch");
  a_nf_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CPS_CTL_LVL_IRQ] && status[CPS_ST_NF] && irq_mask[0] ##0 s_mask_kept |=> irq)
    else $error("nearly full irq missing");
  a_pcm_set: assert property (@(posedge pclk) disable iff (!presetn)
    pcm_need && ctrl[CPS_CTL_EN] |=> status[CPS_ST_PCM])
    else $error("pcm flag not set");
  a_pcm_irq: assert property (@(posedge pclk) disable iff (!presetn)
    status[CPS_ST_PCM] && irq_mask[2] ##0 s_mask_kept |=> irq)
    else $error("pcm irq missing");
  a_und_set: assert property (@(posedge pclk) disable iff (!presetn)
    underrun_event && ctrl[CPS_CTL_EN] |=> status[CPS_ST_UND])
    else $error("underrun not set");
  a_err_irq: assert property (@(posedge pclk) disable iff (!presetn)
    irq_evt[1] && irq_mask[1] ##0 s_mask_kept |=> irq)
    else $error("error irq missing");
  a_und_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_read ##0 prdata[CPS_ST_UND] && !ctrl[CPS_CTL_FREEZE] && !underrun_event
    |=> !status[CPS_ST_UND])
    else $error("underrun not cleared");
  a_ovr_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_read ##0 prdata[CPS_ST_OVR] && !ctrl[CPS_CTL_FREEZE] && !overrun_event
    |=> !status[CPS_ST_OVR])
    else $error("overrun not cleared");
  a_pcm_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_read ##0 prdata[CPS_ST_PCM] && !ctrl[CPS_CTL_FREEZE] && !pcm_need
    |=> !status[CPS_ST_PCM])
    else $error("pcm flag not cleared");
  a_event_wins: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_read ##0 underrun_event |=> status[CPS_ST_UND])
    else $error("underrun lost on read");
  a_ne_kept: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_read ##0 !prdata[CPS_ST_NE] && status[CPS_ST_NE] |=> status[CPS_ST_NE])
    else $error("unreturned flag cleared");
  a_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == CPS_OFS_STATUS |=> $stable(ctrl))
    else $error("status write changed control");
endmodule
`default_nettype wire

// *** sim/cps_top_bench.sv ***
/*
  self-checking bench for cps_top: attenuator table, status flags, irq, dma.
  assumes cps_pkg offsets and an apb slave that answers with pready.
*/
`timescale 1ns/100ps
`default_nettype none
module cps_top_bench
  import cps_pkg::*;
;
  typedef struct {logic [31:0] ctl; logic lg; logic [15:0] din; logic [15:0] dout;} cps_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nf, need, und, ovr;
  logic is_log, law, en, idma, odma, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] ifl, ofl;
  logic [15:0] pin, patt;
  int n_mismatch, total_checks;
  cps_row_s rows [8] = '{
    '{32'h01, 1'h0, 16'h8000, 16'h8000}, '{32'h05, 1'h0, 16'h8000, 16'hC000},
    '{32'h09, 1'h0, 16'h8000, 16'hE000}, '{32'h0D, 1'h0, 16'h8000, 16'hF000},
    '{32'h0D, 1'h0, 16'h7FF8, 16'h0FFF}, '{32'h09, 1'h1, 16'h2001, 16'hE001},
    '{32'h0F, 1'h1, 16'h1001, 16'hF001}, '{32'h03, 1'h1, 16'h1001, 16'h8008}};

  cps_top u_cps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_fill_level(ifl), .output_fill_level(ofl),
    .output_nearly_full(nf), .pcm_need(need), .underrun_event(und), .overrun_event(ovr),
    .pcm_in(pin), .pcm_is_log(is_log), .pcm_att(patt), .companding_law_select(law),
    .module_enable_bit(en), .in_dma_req(idma), .out_dma_req(odma), .irq(irq));

  // ==========================================
  // clock, helpers
  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, q);
    chk("pslverr", 32'h0, pslverr);
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // tests
  initial
  begin
    {presetn, psel, penable, pwrite, nf, need, und, ovr, is_log} = 9'h000;
    {paddr, pwdata, ifl, ofl, pin} = 66'h0;
    n_mismatch = 0;
    total_checks = 0;
    tick(8);
    presetn <= 1'h1;
    rd(CPS_OFS_CTRL, 32'h0, "ctrl reset");
    rd(CPS_OFS_STATUS, 32'h0, "status reset");
    chk("irq reset", 32'h0, irq);
    apb(1'h1, 12'h010, 32'hFF);
    rd(12'h010, 32'h0, "unmapped");
    $display("test reset done");
    foreach (rows[i])
    begin
      apb(1'h1, CPS_OFS_CTRL, rows[i].ctl);
      is_log <= rows[i].lg;
      pin <= rows[i].din;
      tick(2);
      chk("pcm_att", rows[i].dout, patt);
      chk("law", {31'h0, rows[i].ctl[1]}, {31'h0, law});
      chk("enable", 32'h1, {31'h0, en});
    end
    $display("test attenuation done");
    apb(1'h1, CPS_OFS_CTRL, 32'h51);
    ifl <= 3'h4;
    tick(2);
    ifl <= 3'h3;
    tick(3);
    chk("in dma", 32'h1, idma);
    chk("irq masked", 32'h0, irq);
    apb(1'h1, CPS_OFS_IRQ_MASK, 32'h7);
    tick(1);
    chk("irq level", 32'h1, irq);
    rd(CPS_OFS_STATUS, 32'h61, "status ne");
    rd(CPS_OFS_STATUS, 32'h60, "status ne clr");
    tick(1);
    chk("in dma clr", 32'h0, idma);
    apb(1'h1, CPS_OFS_IRQ_STAT, 32'h1);
    tick(1);
    chk("irq clr", 32'h0, irq);
    $display("test nearly empty done");
    apb(1'h1, CPS_OFS_CTRL, 32'hD1);
    nf <= 1'h1;
    ofl <= 3'h5;
    tick(3);
    chk("out dma", 32'h1, odma);
    chk("irq nf", 32'h1, irq);
    rd(CPS_OFS_STATUS, 32'h562, "status nf");
    nf <= 1'h0;
    apb(1'h1, CPS_OFS_IRQ_STAT, 32'h7);
    $display("test nearly full done");
    apb(1'h1, CPS_OFS_CTRL, 32'h21);
    {need, und, ovr} <= 3'h7;
    tick(1);
    {need, und, ovr} <= 3'h0;
    tick(2);
    apb(1'h1, CPS_OFS_STATUS, 32'hFFFF);
    rd(CPS_OFS_STATUS, 32'h57C, "status events");
    rd(CPS_OFS_STATUS, 32'h560, "status events clr");
    rd(CPS_OFS_IRQ_STAT, 32'h6, "irq events");
    apb(1'h1, CPS_OFS_IRQ_STAT, 32'h7);
    apb(1'h1, CPS_OFS_CTRL, 32'h121);
    und <= 1'h1;
    tick(1);
    und <= 1'h0;
    tick(2);
    rd(CPS_OFS_STATUS, 32'h568, "freeze read");
    rd(CPS_OFS_STATUS, 32'h568, "freeze hold");
    apb(1'h1, CPS_OFS_CTRL, 32'h0);
    rd(CPS_OFS_STATUS, 32'h0, "status disabled");
    $display("test events done");
    apb(1'h1, CPS_OFS_CTRL, 32'h0D);
    presetn <= 1'h0;
    tick(2);
    chk("att reset", 32'h0, patt);
    presetn <= 1'h1;
    rd(CPS_OFS_CTRL, 32'h0, "ctrl mid reset");
    $display("test mid reset done");
    conclude();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire
